// [shared/qdlp_pkg.sv]
// Package: command codes, timing counts, register map and carriers
package qdlp_pkg;

    // ***************************************************************
    // Timing
    // ***************************************************************
    localparam int CLOCK_NS       = 100;
    localparam int STROBE_MIN_NS  = 110;   // Narrowest cs/strobe low width
    localparam int HOLD_MIN_NS    = 15;
    localparam int READ_VALID_NS  = 180;
    localparam int FLOAT_NS       = 75;
    localparam int CLEAR_MIN_NS   = 100;
    localparam int STROBE_CYC = (STROBE_MIN_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int HOLD_CYC   = (HOLD_MIN_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int READ_CYC   = (READ_VALID_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int FLOAT_CYC  = (FLOAT_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int CLEAR_CYC  = (CLEAR_MIN_NS + CLOCK_NS - 1) / CLOCK_NS;

    // ***************************************************************
    // Register map (byte addresses)
    // ***************************************************************
    localparam logic [11:0] REG_CMD    = 12'h000;
    localparam logic [11:0] REG_WDATA  = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_RDATA  = 12'h00C;

    // Command register fields
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_OP_W    = 3;
    localparam int CMD_CH_LSB  = 4;
    localparam int CMD_QD_LSB  = 8;
    localparam int CMD_TIE_BIT = 12;     // Bypass enable held low

    localparam int DATA_W = 12;
    localparam int MODE_LSB = 4;         // Mode word in top eight bits

    typedef enum logic [2:0] {
        QDLP_OP_MODE_PRELOAD = 3'h0,
        QDLP_OP_RANK_UPDATE  = 3'h1,
        QDLP_OP_FULL_BYPASS  = 3'h2,
        QDLP_OP_PART_BYPASS  = 3'h3,
        QDLP_OP_READ_CODE    = 3'h4,
        QDLP_OP_READ_MODE    = 3'h5,
        QDLP_OP_CLEAR        = 3'h6,
        QDLP_OP_IDLE         = 3'h7
    } qdlp_op_t;

    // Pin group driven toward the device
    typedef struct packed {
        logic                  chip_select_n;
        logic                  first_rank_load_strobe_n;
        logic                  mode_word_strobe_n;
        logic                  bypass_latch_enable_n;
        logic                  readback_strobe_n;
        logic                  clear_n;
        logic                  quad_pick_0_n;
        logic                  quad_pick_1_n;
        logic                  quad_pick_2_n;
        logic                  channel_pick_0;
        logic                  channel_pick_1;
    } qdlp_pins_t;

    localparam qdlp_pins_t PINS_IDLE = '{
        chip_select_n: 1'b1, first_rank_load_strobe_n: 1'b1,
        mode_word_strobe_n: 1'b1, bypass_latch_enable_n: 1'b1,
        readback_strobe_n: 1'b1, clear_n: 1'b1,
        quad_pick_0_n: 1'b1, quad_pick_1_n: 1'b1, quad_pick_2_n: 1'b1,
        channel_pick_0: 1'b0, channel_pick_1: 1'b0};

    // APB request and answer
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } qdlp_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } qdlp_apb_rsp_t;

endpackage

// [hw/qdlp_apb_regs.sv]
// APB slave holding the controller's command, data and status words
`timescale 1ns/1ps
`default_nettype none

module qdlp_apb_regs (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire qdlp_pkg::qdlp_apb_req_t apb_req,
    output qdlp_pkg::qdlp_apb_rsp_t      apb_rsp,
    input  wire logic                    busy,
    input  wire logic                    done,
    input  wire logic [11:0]             read_word,
    output logic                         start,
    output logic [12:0]                  cmd,
    output logic [11:0]                  wdata
);

    typedef struct packed {
        logic        start;
        logic [12:0] cmd;
        logic [11:0] wdata;
        logic [11:0] rdata;
        logic        done;
    } qdlp_regs_t;

    qdlp_regs_t state;
    qdlp_regs_t next_state;
    logic       access;
    logic       known;

    always_comb begin
        next_state = state;
        next_state.start = 1'b0;
        access = apb_req.psel && apb_req.penable;
        known = apb_req.paddr == qdlp_pkg::REG_CMD
             || apb_req.paddr == qdlp_pkg::REG_WDATA
             || apb_req.paddr == qdlp_pkg::REG_STATUS
             || apb_req.paddr == qdlp_pkg::REG_RDATA;
        // Done is sticky; a new completion wins over the clearing write
        if (access && apb_req.pwrite) begin
            unique case (apb_req.paddr)
                qdlp_pkg::REG_CMD: begin
                    if (!busy) begin
                        next_state.cmd   = apb_req.pwdata[12:0];
                        next_state.start = 1'b1;
                        next_state.done  = 1'b0;
                    end
                end
                qdlp_pkg::REG_WDATA: begin
                    next_state.wdata = apb_req.pwdata[11:0];
                end
                default: begin
                end
            endcase
        end
        if (done) begin
            next_state.done  = 1'b1;
            next_state.rdata = read_word;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Zero wait states; unmapped addresses answer with an error
    always_comb begin
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = apb_req.psel && apb_req.penable && !known;
        apb_rsp.prdata  = 32'h0000_0000;
        if (apb_req.psel && apb_req.penable && !apb_req.pwrite) begin
            unique case (apb_req.paddr)
                qdlp_pkg::REG_CMD:    apb_rsp.prdata = {19'h0_0000, state.cmd};
                qdlp_pkg::REG_WDATA:  apb_rsp.prdata = {20'h0_0000, state.wdata};
                qdlp_pkg::REG_STATUS: apb_rsp.prdata = {30'h0000_0000,
                                                        state.done, busy};
                qdlp_pkg::REG_RDATA:  apb_rsp.prdata = {20'h0_0000, state.rdata};
                default:              apb_rsp.prdata = 32'h0000_0000;
            endcase
        end
    end

    assign start = state.start;
    assign cmd   = state.cmd;
    assign wdata = state.wdata;

endmodule

`default_nettype wire

// [hw/qdlp_host.sv]
// Host controller driving the quad converter's parallel latch port
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module qdlp_host #(
    parameter int STROBE_CYC = qdlp_pkg::STROBE_CYC,
    parameter int HOLD_CYC   = qdlp_pkg::HOLD_CYC,
    parameter int READ_CYC   = qdlp_pkg::READ_CYC,
    parameter int FLOAT_CYC  = qdlp_pkg::FLOAT_CYC,
    parameter int CLEAR_CYC  = qdlp_pkg::CLEAR_CYC
) (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire qdlp_pkg::qdlp_apb_req_t apb_req,
    output qdlp_pkg::qdlp_apb_rsp_t      apb_rsp,
    output qdlp_pkg::qdlp_pins_t         pins,
    input  wire logic [11:0]             data_in,
    output logic [11:0]                  data_out,
    output logic                         data_oe
);

    // ***************************************************************
    // Sequencer state
    // ***************************************************************
    typedef enum logic [2:0] {
        QDLP_IDLE,
        QDLP_SETUP,
        QDLP_STROBE,
        QDLP_RELEASE,
        QDLP_HOLD,
        QDLP_FLOAT
    } qdlp_phase_t;

    typedef struct packed {
        qdlp_phase_t          phase;
        logic [7:0]           count;
        qdlp_pkg::qdlp_pins_t pins;
        logic [11:0]          data_out;
        logic                 data_oe;
        logic [11:0]          capture;
        logic                 done;
        logic [2:0]           op;
        logic                 follow;
    } qdlp_state_t;

    qdlp_state_t state;
    qdlp_state_t next_state;
    logic        start;
    logic [12:0] cmd;
    logic [11:0] wdata;

    function automatic logic [7:0] cyc(input int n);
        cyc = 8'(n);
    endfunction

    qdlp_apb_regs u_regs (
        .clock     (clock),
        .rst_n     (rst_n),
        .apb_req   (apb_req),
        .apb_rsp   (apb_rsp),
        .busy      (state.phase != QDLP_IDLE),
        .done      (state.done),
        .read_word (state.capture),
        .start     (start),
        .cmd       (cmd),
        .wdata     (wdata)
    );

    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        // Live data path while a bypass is open
        if (state.follow && state.data_oe) begin
            next_state.data_out = wdata;
        end
        unique case (state.phase)
            QDLP_IDLE: begin
                if (start) begin
                    next_state.op     = cmd[qdlp_pkg::CMD_OP_LSB +: 3];
                    next_state.pins   = qdlp_pkg::PINS_IDLE;
                    next_state.follow = 1'b0;
                    next_state.pins.quad_pick_0_n =
                        cmd[qdlp_pkg::CMD_QD_LSB];
                    next_state.pins.quad_pick_1_n =
                        cmd[qdlp_pkg::CMD_QD_LSB + 1];
                    next_state.pins.quad_pick_2_n =
                        cmd[qdlp_pkg::CMD_QD_LSB + 2];
                    next_state.pins.channel_pick_0 =
                        cmd[qdlp_pkg::CMD_CH_LSB];
                    next_state.pins.channel_pick_1 =
                        cmd[qdlp_pkg::CMD_CH_LSB + 1];
                    next_state.data_out = wdata;
                    next_state.data_oe  = 1'b0;
                    unique case (qdlp_pkg::qdlp_op_t'(
                        cmd[qdlp_pkg::CMD_OP_LSB +: 3]))
                        qdlp_pkg::QDLP_OP_MODE_PRELOAD: begin
                            // Low nibble is ignored by the device
                            next_state.data_out =
                                {wdata[11:qdlp_pkg::MODE_LSB], 4'h0};
                            next_state.pins.mode_word_strobe_n = 1'b0;
                            next_state.pins.first_rank_load_strobe_n =
                                1'b0;
                            next_state.data_oe = 1'b1;
                        end
                        qdlp_pkg::QDLP_OP_FULL_BYPASS: begin
                            next_state.pins.quad_pick_0_n = 1'b0;
                            next_state.pins.quad_pick_1_n = 1'b0;
                            next_state.pins.quad_pick_2_n = 1'b0;
                            next_state.pins.bypass_latch_enable_n = 1'b0;
                            next_state.data_oe = 1'b1;
                            next_state.follow  = 1'b1;
                        end
                        qdlp_pkg::QDLP_OP_PART_BYPASS: begin
                            next_state.pins.quad_pick_0_n = 1'b0;
                            next_state.pins.quad_pick_1_n = 1'b0;
                            next_state.pins.quad_pick_2_n = 1'b0;
                            next_state.pins.first_rank_load_strobe_n = 1'b0;
                            next_state.pins.bypass_latch_enable_n = 1'b0;
                            next_state.data_oe = 1'b1;
                            next_state.follow  = 1'b1;
                        end
                        qdlp_pkg::QDLP_OP_READ_MODE: begin
                            next_state.pins.mode_word_strobe_n = 1'b0;
                            next_state.pins.quad_pick_0_n = 1'b0;
                            next_state.pins.quad_pick_1_n = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                    // Tied-low bypass option keeps the pin low at rest
                    if (cmd[qdlp_pkg::CMD_TIE_BIT]) begin
                        next_state.pins.bypass_latch_enable_n = 1'b0;
                    end
                    if (cmd[qdlp_pkg::CMD_OP_LSB +: 3] ==
                        qdlp_pkg::QDLP_OP_IDLE) begin
                        next_state.done = 1'b1;
                    end else begin
                        next_state.phase = QDLP_SETUP;
                    end
                end
            end
            QDLP_SETUP: begin
                // Address and data settle one cycle before the strobe
                next_state.count = cyc(STROBE_CYC);
                next_state.phase = QDLP_STROBE;
                unique case (qdlp_pkg::qdlp_op_t'(state.op))
                    qdlp_pkg::QDLP_OP_CLEAR: begin
                        next_state.pins.clear_n = 1'b0;
                        next_state.count = cyc(CLEAR_CYC);
                    end
                    qdlp_pkg::QDLP_OP_READ_CODE,
                    qdlp_pkg::QDLP_OP_READ_MODE: begin
                        next_state.pins.readback_strobe_n = 1'b0;
                        next_state.pins.chip_select_n = 1'b0;
                        next_state.count = cyc(READ_CYC);
                    end
                    qdlp_pkg::QDLP_OP_RANK_UPDATE: begin
                        next_state.pins.chip_select_n = 1'b0;
                    end
                    default: begin
                        // Bypass and mode preload loads reach the converter here
                        next_state.pins.chip_select_n = 1'b0;
                    end
                endcase
            end
            QDLP_STROBE: begin
                if (state.count > cyc(1)) begin
                    next_state.count = state.count - cyc(1);
                end else begin
                    // Full 12-bit word taken at once
                    if (!state.pins.readback_strobe_n) begin
                        next_state.capture = data_in;
                    end
                    next_state.pins.chip_select_n = 1'b1;
                    next_state.pins.readback_strobe_n = 1'b1;
                    next_state.pins.clear_n = 1'b1;
                    next_state.count = cyc(HOLD_CYC);
                    next_state.phase = QDLP_RELEASE;
                end
            end
            QDLP_RELEASE: begin
                // Load strobes lift only after select: first rank, mode word, and bypass unless the tie bit is set
                if (state.count > cyc(1)) begin
                    next_state.count = state.count - cyc(1);
                end else begin
                    next_state.pins.first_rank_load_strobe_n = 1'b1;
                    next_state.pins.mode_word_strobe_n = 1'b1;
                    if (!cmd[qdlp_pkg::CMD_TIE_BIT]) begin
                        next_state.pins.bypass_latch_enable_n = 1'b1;
                    end
                    next_state.follow = 1'b0;
                    next_state.count = cyc(HOLD_CYC);
                    next_state.phase = QDLP_HOLD;
                end
            end
            QDLP_HOLD: begin
                if (state.count > cyc(1)) begin
                    next_state.count = state.count - cyc(1);
                end else begin
                    next_state.data_oe = 1'b0;
                    next_state.count = cyc(FLOAT_CYC);
                    next_state.phase = QDLP_FLOAT;
                end
            end
            QDLP_FLOAT: begin
                // Device bus turnaround before next command
                if (state.count > cyc(1)) begin
                    next_state.count = state.count - cyc(1);
                end else begin
                    next_state.done  = 1'b1;
                    next_state.phase = QDLP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= '{phase: QDLP_IDLE, count: 8'h00,
                       pins: qdlp_pkg::PINS_IDLE, data_out: 12'h000,
                       data_oe: 1'b0, capture: 12'h000, done: 1'b0,
                       op: 3'h7, follow: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign pins     = state.pins;
    assign data_out = state.data_out;
    assign data_oe  = state.data_oe;

endmodule

`default_nettype wire

// [tb/qdlp_host_assertions.sv]
// Concurrent checks on the host controller ports
`timescale 1ns/1ps
`default_nettype none

module qdlp_host_chk #(
    parameter int STROBE_CYC = qdlp_pkg::STROBE_CYC,
    parameter int READ_CYC   = qdlp_pkg::READ_CYC
) (
    input wire logic                    clock,
    input wire logic                    rst_n,
    input wire qdlp_pkg::qdlp_apb_req_t apb_req,
    input wire qdlp_pkg::qdlp_apb_rsp_t apb_rsp,
    input wire qdlp_pkg::qdlp_pins_t    pins,
    input wire logic [11:0]             data_in,
    input wire logic [11:0]             data_out,
    input wire logic                    data_oe
);
    wire        sel_n = pins.chip_select_n;
    wire        ld_n  = pins.first_rank_load_strobe_n;
    wire        md_n  = pins.mode_word_strobe_n;
    wire        byp_n = pins.bypass_latch_enable_n;
    wire        rdb_n = pins.readback_strobe_n;
    wire        q_lo  = !(pins.quad_pick_0_n | pins.quad_pick_1_n
                          | pins.quad_pick_2_n);
    wire        acc   = apb_req.psel && apb_req.penable;
    logic [7:0] low_cnt;

    // Select low time, counted so the figure may be any parameter value
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            low_cnt <= 8'h00;
        else if (!sel_n)
            low_cnt <= low_cnt + 8'h01;
        else
            low_cnt <= 8'h00;
    end

    default clocking dflt @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_zero_wait: assert property (acc |-> apb_rsp.pready)
        else $error("pready low in access phase");
    a_addr_decode: assert property (acc && apb_req.paddr[1:0] == 2'h0
        |-> apb_rsp.pslverr == (apb_req.paddr > 12'h00C))
        else $error("pslverr wrong for address");
    a_no_fight: assert property (!rdb_n && !sel_n |-> !data_oe)
        else $error("host drives data during readback");
    a_full_pins: assert property (!sel_n && !byp_n && ld_n
        |-> md_n && rdb_n && q_lo && data_oe)
        else $error("full bypass pin pattern wrong");
    a_part_pins: assert property (!sel_n && !byp_n && !ld_n
        |-> md_n && rdb_n && q_lo && data_oe)
        else $error("partial bypass pin pattern wrong");
    a_preload_order: assert property ($rose(ld_n) && !$past(md_n)
        |-> sel_n && $past(sel_n))
        else $error("load strobe rose before select");
    a_read_code: assert property ($fell(rdb_n)
        |-> $fell(sel_n) && byp_n && ld_n && pins.clear_n)
        else $error("readback pin pattern wrong");
    a_read_mode: assert property (!rdb_n && !md_n
        |-> !pins.quad_pick_0_n && !pins.quad_pick_1_n && byp_n
            && pins.clear_n)
        else $error("mode readback pin pattern wrong");
    a_update_pins: assert property ($fell(sel_n) && ld_n && md_n
        && byp_n && rdb_n |-> pins.clear_n && !data_oe)
        else $error("update pulse strobes wrong");
    a_select_width: assert property ($rose(sel_n)
        |-> low_cnt == STROBE_CYC || low_cnt == READ_CYC)
        else $error("select low width wrong");
    a_oe_release: assert property ($rose(sel_n) && data_oe
        |-> ##[1:4] !data_oe)
        else $error("data drive not released");

    c_full: cover property (!sel_n && !byp_n && ld_n);
    c_part: cover property (!sel_n && !byp_n && !ld_n);
    c_read: cover property (!sel_n && !rdb_n && !md_n);
    c_clear: cover property ($fell(pins.clear_n));
endmodule

bind qdlp_host qdlp_host_chk #(
    .STROBE_CYC(STROBE_CYC),
    .READ_CYC  (READ_CYC)
) qdlp_host_chk_inst (
    .clock(clock), .rst_n(rst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .pins(pins), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe)
);
`default_nettype wire

// [tb/qdlp_dev_model.sv]
// Behavioural model of the quad converter latch port
`timescale 1ns/1ps
`default_nettype none

module qdlp_dev_model (
    input  wire qdlp_pkg::qdlp_pins_t pins,
    input  wire logic [11:0]          host_word,
    input  wire logic                 host_oe,
    output logic [11:0]               dev_word
);
    logic [3:0][11:0] rank1;
    logic [3:0][11:0] rank2;
    logic [7:0]       mode1;
    logic [7:0]       mode2;
    logic [11:0]      word;
    logic [11:0]      last;
    logic             valid;
    wire  [1:0]       ch = {pins.channel_pick_1, pins.channel_pick_0};
    wire              q_on = !(pins.quad_pick_0_n | pins.quad_pick_1_n
                               | pins.quad_pick_2_n);
    // Undriven data lines never repeat the last word
    wire  [11:0]      bus = host_oe ? host_word : ~host_word;
    wire              wr_on = !pins.chip_select_n && pins.clear_n
                              && pins.readback_strobe_n;
    wire              rd_on = !pins.chip_select_n && pins.clear_n
                              && !pins.readback_strobe_n;

    initial begin
        rank1 = '0;
        rank2 = '0;
        mode1 = '0;
        mode2 = '0;
        last  = '0;
        valid = 1'b0;
    end

    // ***************************************************************
    // Level latches: the device has no clock
    // ***************************************************************
    always @* begin
        if (!pins.clear_n) begin
            rank1 = '0;
            rank2 = '0;
            mode1 = '0;
            mode2 = '0;
        end else if (wr_on && pins.bypass_latch_enable_n) begin
            if (!pins.mode_word_strobe_n && !pins.first_rank_load_strobe_n)
                mode1 = bus[11:4];
            if (pins.mode_word_strobe_n && pins.first_rank_load_strobe_n) begin
                rank2 = rank1;
                mode2 = mode1;
            end
        end else if (wr_on && pins.mode_word_strobe_n && q_on) begin
            if (pins.first_rank_load_strobe_n)
                rank2 = {4{bus}};
            else
                rank2[ch] = bus;
        end
    end

    // ***************************************************************
    // Readback, valid only after the access time
    // ***************************************************************
    always @(rd_on) begin
        valid = 1'b0;
        if (rd_on)
            valid <= #180 1'b1;
    end

    always @* begin
        if (!pins.mode_word_strobe_n)
            word = {mode2, 4'h0};
        else
            word = q_on ? rank2[ch] : ~last;
    end

    always @(negedge valid) begin
        last = word;
    end

    assign dev_word = (rd_on && valid) ? word : ~last;
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the quad converter host controller
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, s) \
    begin n_compared++; if ((s) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", n, e, s); end end

module tb_top;
    logic                    clock;
    logic                    rst_n;
    qdlp_pkg::qdlp_apb_req_t req;
    qdlp_pkg::qdlp_apb_rsp_t rsp;
    qdlp_pkg::qdlp_pins_t    pins;
    logic [11:0]             dev_word;
    logic [11:0]             host_word;
    logic                    host_oe;
    int                      err_total;
    int                      n_compared;
    logic [3:0][11:0]        ec;
    logic [7:0]              em;
    logic [31:0]             rd;
    logic                    er;

    qdlp_host qdlp_host_inst (
        .clock(clock), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
        .pins(pins), .data_in(dev_word), .data_out(host_word),
        .data_oe(host_oe));
    qdlp_dev_model qdlp_dev_model_inst (
        .pins(pins), .host_word(host_word), .host_oe(host_oe),
        .dev_word(dev_word));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ***************************************************************
    // Bus cycles
    // ***************************************************************
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int k;
        @(posedge clock);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock);
        req.penable <= 1'b1;
        k = 0;
        // Request stands until pready is seen high at a rising edge
        do begin
            @(posedge clock);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            err_total++;
            stop_test();
        end
        r = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask

    task automatic run(input qdlp_pkg::qdlp_op_t op, input logic [1:0] ch,
                       input logic [11:0] d, input logic tie);
        int k;
        apb(1'b1, qdlp_pkg::REG_WDATA, {20'h0_0000, d}, rd, er);
        apb(1'b1, qdlp_pkg::REG_CMD,
            {19'h0, tie, 1'b0, 3'h0, 2'h0, ch, 1'b0, op}, rd, er);
        k = 0;
        do begin
            apb(1'b0, qdlp_pkg::REG_STATUS, 32'h0, rd, er);
            k++;
        end while (rd[1] !== 1'b1 && k < 50);
        if (k >= 50) begin
            err_total++;
            stop_test();
        end
    endtask

    task automatic chk_all();
        for (int i = 0; i < 4; i++) begin
            run(qdlp_pkg::QDLP_OP_READ_CODE, i[1:0], 12'h000, 1'b0);
            apb(1'b0, qdlp_pkg::REG_RDATA, 32'h0, rd, er);
            `CHK("code", ec[i], rd[11:0])
        end
    endtask

    task automatic chk_mode();
        run(qdlp_pkg::QDLP_OP_READ_MODE, 2'h0, 12'h000, 1'b0);
        apb(1'b0, qdlp_pkg::REG_RDATA, 32'h0, rd, er);
        `CHK("mode", em, rd[11:4])
    endtask

    // ***************************************************************
    // Main sequence
    // ***************************************************************
    initial begin
        logic [11:0] d;
        logic [1:0]  c;
        logic [7:0]  m;
        err_total = 0;
        n_compared = 0;
        req = '0;
        rst_n = 1'b0;
        void'($urandom(16416));
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, 12'h010, 32'h0, rd, er);
        `CHK("unmapped", 1'b1, er)
        apb(1'b0, qdlp_pkg::REG_STATUS, 32'h0, rd, er);
        `CHK("busy", 1'b0, rd[0])
        ec = '0;
        em = 8'h00;
        chk_all();
        for (int t = 0; t < 4; t++) begin
            d = (t == 0) ? 12'hFFF : 12'($urandom);
            run(qdlp_pkg::QDLP_OP_FULL_BYPASS, 2'h0, d, t[0]);
            ec = {4{d}};
            chk_all();
        end
        for (int t = 0; t < 8; t++) begin
            c = 2'($urandom);
            d = (t == 1) ? 12'h000 : 12'($urandom);
            run(qdlp_pkg::QDLP_OP_PART_BYPASS, c, d, t[0]);
            ec[c] = d;
            chk_all();
        end
        // Low nibble set so a mode word taken from it shows up
        m = 8'($urandom);
        run(qdlp_pkg::QDLP_OP_MODE_PRELOAD, 2'h0, {m, 4'hA}, 1'b0);
        chk_mode();
        run(qdlp_pkg::QDLP_OP_RANK_UPDATE, 2'h0, 12'h000, 1'b0);
        em = m;
        ec = '0;
        chk_mode();
        chk_all();
        run(qdlp_pkg::QDLP_OP_FULL_BYPASS, 2'h0, 12'hA5A, 1'b0);
        run(qdlp_pkg::QDLP_OP_MODE_PRELOAD, 2'h0, {~m, 4'h0}, 1'b0);
        run(qdlp_pkg::QDLP_OP_CLEAR, 2'h0, 12'h000, 1'b0);
        em = 8'h00;
        chk_mode();
        chk_all();
        run(qdlp_pkg::QDLP_OP_IDLE, 2'h0, 12'h000, 1'b0);
        `CHK("idle", 1'b0, rd[0])
        stop_test();
    end
endmodule
`default_nettype wire
